// ===== src/smt_share_consts.svh
// constants for the two-thread pipeline sharing block
`ifndef SMT_SHARE_CONSTS_SVH
`define SMT_SHARE_CONSTS_SVH
`define UOPQ_DEPTH 16
`define RENQ_DEPTH 16
`define ROB_DEPTH 32
`define LDB_DEPTH 16
`define STB_DEPTH 16
`define DISPATCH_MAX 6
`define DTB_ENTRIES 8
`define DTB_VPN_W 20
`define DTB_PPN_W 20
`define DTB_RESET_VALID 8'h00
`endif

// ===== src/smt_share_pkg.sv
// types for the two-thread pipeline sharing block
package smt_share_pkg;
  typedef logic thread_type;
  typedef enum logic {
    mode_shared,
    mode_adaptive
  } l1_mode_type;
endpackage : smt_share_pkg

// ===== src/thread_partition.sv
// one partitioned staging buffer: per-thread occupancy with half caps
`timescale 1ns/10ps
`include "smt_share_consts.svh"
module thread_partition
  import smt_share_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_active,
  input wire logic [1:0] i_alloc,
  input wire logic [1:0] i_free,
  output logic [1:0] o_ready,
  output logic [1:0] o_full,
  output logic [7:0] o_count0,
  output logic [7:0] o_count1
);
  localparam logic [7:0] HALF = 8'(DEPTH / 2);

  logic [7:0] count [2];
  logic [7:0] next_count [2];
  logic [1:0] ready;
  logic [1:0] next_ready;
  logic [1:0] full;
  logic [1:0] next_full;

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      next_count[t] = count[t];
      if (!i_active[t]) begin
        next_count[t] = 8'h00;
      end else begin
        if (i_alloc[t] && ready[t])
          next_count[t] = next_count[t] + 8'h01;
        if (i_free[t] && count[t] != 8'h00)
          next_count[t] = next_count[t] - 8'h01;
      end
      // cap at half so one stalled thread never starves the other
      next_full[t] = (next_count[t] >= HALF);
      next_ready[t] = i_active[t] && !next_full[t];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count[0] <= 8'h00;
      count[1] <= 8'h00;
      ready <= 2'h0;
      full <= 2'h0;
    end else begin
      count <= next_count;
      ready <= next_ready;
      full <= next_full;
    end
  end

  assign o_ready = ready;
  assign o_full = full;
  assign o_count0 = count[0];
  assign o_count1 = count[1];
endmodule : thread_partition

// ===== src/two_thread_pipeline_sharing.sv
// two-thread sharing control: partitions, thread-tagged lookup, selectors
//
// Summary of operation
// - each thread holds at most half a buffer
// - all staging buffers partitioned per thread
// - load/store ordering checked inside own partition
// - translation entries hit on matching thread, or any thread if global in adaptive mode
// - context bit selects shared or adaptive cache
// - adaptive mode maps page accesses identically
// - selection points alternate, else grant other
// - fetch arbitrated each clock, alternating
// - stalled thread yields fetch until refill returns
// - fetch-to-rename queue partitioned when both active
// - dispatch at most six ready micro-ops
// - dispatch ignores thread of queued micro-ops
// - reorder buffer split half per thread
// - retire per thread in order, alternating
// - idle retiring thread gives all to other
// - store commit alternates between threads
// - per-thread pointer and return stack state
`timescale 1ns/10ps
`include "smt_share_consts.svh"
module two_thread_pipeline_sharing
  import smt_share_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_active,
  input wire logic [1:0] i_fetch_req,
  input wire logic [1:0] i_fetch_miss,
  input wire logic [1:0] i_l2_return,
  input wire logic [1:0] i_uopq_alloc,
  input wire logic [1:0] i_uopq_free,
  input wire logic [1:0] i_renq_alloc,
  input wire logic [1:0] i_renq_free,
  input wire logic [1:0] i_rob_alloc,
  input wire logic [1:0] i_rob_free,
  input wire logic [1:0] i_ldb_alloc,
  input wire logic [1:0] i_ldb_free,
  input wire logic [1:0] i_stb_alloc,
  input wire logic [1:0] i_stb_free,
  input wire logic [1:0] i_order_viol,
  input wire logic [15:0] i_sched_ready,
  input wire logic [1:0] i_retire_ready,
  input wire logic [1:0] i_store_pending,
  input wire logic i_ctx_bit,
  input wire logic i_dtb_lookup,
  input wire logic i_dtb_thread,
  input wire logic [`DTB_VPN_W-1:0] i_dtb_vpn,
  input wire logic i_dtb_fill,
  input wire logic i_dtb_fill_thread,
  input wire logic i_dtb_fill_global,
  input wire logic [`DTB_VPN_W-1:0] i_dtb_fill_vpn,
  input wire logic [`DTB_PPN_W-1:0] i_dtb_fill_ppn,
  input wire logic [1:0] i_branch,
  input wire logic [1:0] i_call,
  input wire logic [1:0] i_ret,
  input wire logic [31:0] i_target,
  output logic [1:0] o_fetch_grant,
  output logic [1:0] o_retire_grant,
  output logic [1:0] o_commit_grant,
  output logic [15:0] o_dispatch,
  output logic [1:0] o_uopq_ready,
  output logic [1:0] o_renq_ready,
  output logic [1:0] o_rob_ready,
  output logic [1:0] o_ldb_ready,
  output logic [1:0] o_stb_ready,
  output logic [1:0] o_order_flush,
  output logic o_dtb_hit,
  output logic [`DTB_PPN_W-1:0] o_dtb_ppn,
  output logic o_l1_adaptive,
  output logic [31:0] o_ip0,
  output logic [31:0] o_ip1,
  output logic [31:0] o_ret_top0,
  output logic [31:0] o_ret_top1
);

  // ------------------------------------------------------------
  // alternating selection
  // ------------------------------------------------------------
  // last holder gets lower priority next; idle cycles keep history
  function automatic logic [1:0] pick(input logic [1:0] req,
                                      input logic last);
    logic [1:0] g;
    g = 2'h0;
    if (req == 2'h3)
      g = last ? 2'h1 : 2'h2;
    else
      g = req;
    return g;
  endfunction : pick

  function automatic logic upd_last(input logic [1:0] g, input logic last);
    return (g == 2'h0) ? last : g[1];
  endfunction : upd_last

  logic [1:0] fetch_wait;
  logic [1:0] next_fetch_wait;
  logic [1:0] fetch_grant, next_fetch_grant;
  logic [1:0] retire_grant, next_retire_grant;
  logic [1:0] commit_grant, next_commit_grant;
  logic last_fetch, next_last_fetch;
  logic last_retire, next_last_retire;
  logic last_commit, next_last_commit;
  logic [1:0] fetch_elig;

  always_comb begin
    next_fetch_wait = fetch_wait;
    for (int t = 0; t < 2; t++) begin
      if (i_fetch_miss[t])
        next_fetch_wait[t] = 1'b1;
      else if (i_l2_return[t])
        next_fetch_wait[t] = 1'b0;
    end
    fetch_elig = i_fetch_req & i_active & ~fetch_wait;
    next_fetch_grant = pick(fetch_elig, last_fetch);
    next_last_fetch = upd_last(next_fetch_grant, last_fetch);
    // retirement is per-thread in order; ready means oldest is done
    next_retire_grant = pick(i_retire_ready & i_active,
                             last_retire);
    next_last_retire = upd_last(next_retire_grant, last_retire);
    next_commit_grant = pick(i_store_pending & i_active,
                             last_commit);
    next_last_commit = upd_last(next_commit_grant, last_commit);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fetch_wait <= 2'h0;
      fetch_grant <= 2'h0;
      retire_grant <= 2'h0;
      commit_grant <= 2'h0;
      last_fetch <= 1'b1;
      last_retire <= 1'b1;
      last_commit <= 1'b1;
    end else begin
      fetch_wait <= next_fetch_wait;
      fetch_grant <= next_fetch_grant;
      retire_grant <= next_retire_grant;
      commit_grant <= next_commit_grant;
      last_fetch <= next_last_fetch;
      last_retire <= next_last_retire;
      last_commit <= next_last_commit;
    end
  end

  assign o_fetch_grant = fetch_grant;
  assign o_retire_grant = retire_grant;
  assign o_commit_grant = commit_grant;

  // ------------------------------------------------------------
  // partitioned staging buffers
  // ------------------------------------------------------------
  thread_partition #(.DEPTH(`UOPQ_DEPTH)) u_uopq (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_active(i_active),
    .i_alloc(i_uopq_alloc), .i_free(i_uopq_free),
    .o_ready(o_uopq_ready), .o_full(), .o_count0(), .o_count1());
  thread_partition #(.DEPTH(`RENQ_DEPTH)) u_renq (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_active(i_active),
    .i_alloc(i_renq_alloc), .i_free(i_renq_free),
    .o_ready(o_renq_ready), .o_full(), .o_count0(), .o_count1());
  thread_partition #(.DEPTH(`ROB_DEPTH)) u_rob (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_active(i_active),
    .i_alloc(i_rob_alloc), .i_free(i_rob_free),
    .o_ready(o_rob_ready), .o_full(), .o_count0(), .o_count1());
  thread_partition #(.DEPTH(`LDB_DEPTH)) u_ldb (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_active(i_active),
    .i_alloc(i_ldb_alloc), .i_free(i_ldb_free),
    .o_ready(o_ldb_ready), .o_full(), .o_count0(), .o_count1());
  thread_partition #(.DEPTH(`STB_DEPTH)) u_stb (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_active(i_active),
    .i_alloc(i_stb_alloc), .i_free(i_stb_free),
    .o_ready(o_stb_ready), .o_full(), .o_count0(), .o_count1());

  // violation flushes only the offending thread's partition
  logic [1:0] order_flush, next_order_flush;
  always_comb begin
    next_order_flush = i_order_viol & i_active;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      order_flush <= 2'h0;
    else
      order_flush <= next_order_flush;
  end
  assign o_order_flush = order_flush;

  // ------------------------------------------------------------
  // dispatch
  // ------------------------------------------------------------
  // lowest slots first; no thread field is even looked at
  logic [15:0] dispatch, next_dispatch;
  always_comb begin
    logic [3:0] n;
    n = 4'h0;
    next_dispatch = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (i_sched_ready[i] && n < 4'(`DISPATCH_MAX)) begin
        next_dispatch[i] = 1'b1;
        n = n + 4'h1;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      dispatch <= 16'h0000;
    else
      dispatch <= next_dispatch;
  end
  assign o_dispatch = dispatch;

  // ------------------------------------------------------------
  // thread-tagged translation buffer and cache mode
  // ------------------------------------------------------------
  logic [`DTB_ENTRIES-1:0] dtb_valid, next_dtb_valid;
  logic [`DTB_ENTRIES-1:0] dtb_tid, next_dtb_tid;
  logic [`DTB_ENTRIES-1:0] dtb_glob, next_dtb_glob;
  logic [`DTB_VPN_W-1:0] dtb_vpn [`DTB_ENTRIES];
  logic [`DTB_VPN_W-1:0] next_dtb_vpn [`DTB_ENTRIES];
  logic [`DTB_PPN_W-1:0] dtb_ppn [`DTB_ENTRIES];
  logic [`DTB_PPN_W-1:0] next_dtb_ppn [`DTB_ENTRIES];
  logic [2:0] fill_ptr, next_fill_ptr;
  logic dtb_hit, next_dtb_hit;
  logic [`DTB_PPN_W-1:0] dtb_out, next_dtb_out;
  logic l1_adaptive, next_l1_adaptive;

  always_comb begin
    next_dtb_valid = dtb_valid;
    next_dtb_tid = dtb_tid;
    next_dtb_glob = dtb_glob;
    next_dtb_vpn = dtb_vpn;
    next_dtb_ppn = dtb_ppn;
    next_fill_ptr = fill_ptr;
    next_dtb_hit = 1'b0;
    next_dtb_out = '0;
    next_l1_adaptive = (i_ctx_bit ? mode_adaptive : mode_shared)
                       == mode_adaptive;
    if (i_dtb_lookup) begin
      for (int i = 0; i < `DTB_ENTRIES; i++) begin
        // page-directory entries are shared only in adaptive mode
        if (dtb_valid[i] && dtb_vpn[i] == i_dtb_vpn &&
            (dtb_tid[i] == i_dtb_thread ||
             (l1_adaptive && dtb_glob[i]))) begin
          next_dtb_hit = 1'b1;
          next_dtb_out = dtb_ppn[i];
        end
      end
    end
    if (i_dtb_fill) begin
      next_dtb_valid[fill_ptr] = 1'b1;
      next_dtb_tid[fill_ptr] = i_dtb_fill_thread;
      next_dtb_glob[fill_ptr] = i_dtb_fill_global;
      next_dtb_vpn[fill_ptr] = i_dtb_fill_vpn;
      next_dtb_ppn[fill_ptr] = i_dtb_fill_ppn;
      next_fill_ptr = fill_ptr + 3'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dtb_valid <= `DTB_RESET_VALID;
      dtb_tid <= 8'h00;
      dtb_glob <= 8'h00;
      for (int i = 0; i < `DTB_ENTRIES; i++) begin
        dtb_vpn[i] <= '0;
        dtb_ppn[i] <= '0;
      end
      fill_ptr <= 3'h0;
      dtb_hit <= 1'b0;
      dtb_out <= '0;
      l1_adaptive <= 1'b0;
    end else begin
      dtb_valid <= next_dtb_valid;
      dtb_tid <= next_dtb_tid;
      dtb_glob <= next_dtb_glob;
      dtb_vpn <= next_dtb_vpn;
      dtb_ppn <= next_dtb_ppn;
      fill_ptr <= next_fill_ptr;
      dtb_hit <= next_dtb_hit;
      dtb_out <= next_dtb_out;
      l1_adaptive <= next_l1_adaptive;
    end
  end

  assign o_dtb_hit = dtb_hit;
  assign o_dtb_ppn = dtb_out;
  assign o_l1_adaptive = l1_adaptive;

  // ------------------------------------------------------------
  // replicated per-thread state
  // ------------------------------------------------------------
  // one-deep return stack per thread keeps area small
  logic [31:0] ip [2];
  logic [31:0] next_ip [2];
  logic [31:0] rtop [2];
  logic [31:0] next_rtop [2];
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      next_ip[t] = ip[t];
      next_rtop[t] = rtop[t];
      if (i_call[t])
        next_rtop[t] = ip[t] + 32'h4;
      if (i_ret[t])
        next_ip[t] = rtop[t];
      else if (i_branch[t] || i_call[t])
        next_ip[t] = i_target;
      else if (fetch_grant[t])
        next_ip[t] = ip[t] + 32'h10;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ip[0] <= 32'h0;
      ip[1] <= 32'h0;
      rtop[0] <= 32'h0;
      rtop[1] <= 32'h0;
    end else begin
      ip <= next_ip;
      rtop <= next_rtop;
    end
  end
  assign o_ip0 = ip[0];
  assign o_ip1 = ip[1];
  assign o_ret_top0 = rtop[0];
  assign o_ret_top1 = rtop[1];
endmodule : two_thread_pipeline_sharing

// ===== tb/smt_share_properties.sv
// port assertions for the two-thread sharing block
`timescale 1ns/10ps
module smt_share_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_active,
  input wire logic [1:0] i_fetch_req,
  input wire logic [1:0] i_fetch_miss,
  input wire logic [1:0] i_l2_return,
  input wire logic [15:0] i_sched_ready,
  input wire logic [1:0] i_retire_ready,
  input wire logic [1:0] i_store_pending,
  input wire logic i_ctx_bit,
  input wire logic [1:0] o_fetch_grant,
  input wire logic [1:0] o_retire_grant,
  input wire logic [1:0] o_commit_grant,
  input wire logic [15:0] o_dispatch,
  input wire logic [1:0] o_uopq_ready,
  input wire logic [1:0] o_rob_ready,
  input wire logic o_l1_adaptive
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  function automatic logic [15:0] low6(logic [15:0] r);
    int n = 0;
    low6 = '0;
    for (int i = 0; i < 16; i++)
      if (r[i] && n < 6) begin
        low6[i] = 1'b1;
        n++;
      end
  endfunction : low6
  a_retire_alt: assert property (
    i_active == 2'h3 && i_retire_ready == 2'h3 && o_retire_grant == 2'h1
    |=> o_retire_grant == 2'h2) else $error("retire did not alternate");
  a_retire_solo: assert property (
    i_active == 2'h3 && i_retire_ready == 2'h1 |=> o_retire_grant == 2'h1)
    else $error("lone ready thread lost retire slot");
  a_commit_alt: assert property (
    i_active == 2'h3 && i_store_pending == 2'h3 && o_commit_grant == 2'h2
    |=> o_commit_grant == 2'h1) else $error("commit did not alternate");
  a_fetch_idle: assert property (
    i_fetch_req == 2'h0 |=> o_fetch_grant == 2'h0)
    else $error("fetch granted with no request");
  a_fetch_stall: assert property (
    i_fetch_miss[0] ##1 !i_l2_return[0] |=> !o_fetch_grant[0])
    else $error("stalled thread fetched before refill");
  a_dispatch_pick: assert property (
    1'b1 |=> o_dispatch == low6($past(i_sched_ready)))
    else $error("dispatch set wrong");
  a_queue_idle: assert property (
    !i_active[0] |=> !o_uopq_ready[0])
    else $error("inactive thread queue ready");
  a_rob_idle: assert property (
    !i_active[1] |=> !o_rob_ready[1])
    else $error("inactive thread reorder ready");
  a_l1_mode: assert property (
    1'b1 |=> o_l1_adaptive == $past(i_ctx_bit))
    else $error("cache mode does not follow context bit");
  c_alt: cover property (o_retire_grant == 2'h1 ##1 o_retire_grant == 2'h2);
  c_cap: cover property (i_active[0] && $fell(o_uopq_ready[0]));
  c_refill: cover property (i_fetch_miss[0] ##[2:9] i_l2_return[0]);
endmodule : smt_share_properties

// ===== tb/smt_share_l2_model.sv
// second-level cache refill model for missed fetches
`timescale 1ns/10ps
module smt_share_l2_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_miss,
  output logic [1:0] o_return = 2'h0
);
  int cnt [2];
  // latency mixes prompt and slow refills
  always @(posedge i_clk or negedge i_rst_n) begin
    for (int t = 0; t < 2; t++)
      if (!i_rst_n) cnt[t] = 0;
      else if (i_miss[t]) cnt[t] = $urandom_range(9, 2);
      else if (cnt[t] > 0) cnt[t]--;
  end
  // pulse driven off the sampling edge to avoid races
  always @(negedge i_clk or negedge i_rst_n) begin
    for (int t = 0; t < 2; t++)
      o_return[t] <= i_rst_n && cnt[t] == 1;
  end
endmodule : smt_share_l2_model

// ===== tb/two_thread_pipeline_sharing_bench.sv
// self-checking bench for the two-thread sharing block
`timescale 1ns/10ps
`include "smt_share_consts.svh"
module two_thread_pipeline_sharing_bench;
  import smt_share_pkg::*;
  logic i_clk, i_rst_n, i_ctx_bit, i_dtb_lookup, i_dtb_thread, i_dtb_fill;
  logic i_dtb_fill_thread, i_dtb_fill_global;
  logic [1:0] i_active, freq, i_fetch_miss, i_l2_return, i_retire_ready;
  logic [1:0] i_store_pending, i_order_viol, i_branch, i_call, i_ret;
  logic [1:0] o_fetch_grant, o_retire_grant, o_commit_grant;
  logic [9:0] al, fr, rd;
  logic [15:0] i_sched_ready, o_dispatch;
  logic [`DTB_VPN_W-1:0] i_dtb_vpn, i_dtb_fill_vpn;
  logic [`DTB_PPN_W-1:0] i_dtb_fill_ppn;
  logic [31:0] i_target;
  logic [1:0] o_order_flush;
  logic o_dtb_hit;
  logic [`DTB_PPN_W-1:0] o_dtb_ppn;
  logic [31:0] o_ip0, o_ip1, o_ret_top0, o_ret_top1;
  logic o_l1_adaptive;
  wire [1:0] fq = freq & ~i_fetch_miss & ~i_l2_return;
  int error_cnt = 0;
  int comparisons = 0;
  int dp [5] = '{`UOPQ_DEPTH, `RENQ_DEPTH, `ROB_DEPTH, `LDB_DEPTH, `STB_DEPTH};
  two_thread_pipeline_sharing two_thread_pipeline_sharing_i (.*,
    .i_fetch_req(fq), .i_uopq_alloc(al[1:0]), .i_uopq_free(fr[1:0]),
    .i_renq_alloc(al[3:2]), .i_renq_free(fr[3:2]),
    .i_rob_alloc(al[5:4]), .i_rob_free(fr[5:4]),
    .i_ldb_alloc(al[7:6]), .i_ldb_free(fr[7:6]),
    .i_stb_alloc(al[9:8]), .i_stb_free(fr[9:8]),
    .o_uopq_ready(rd[1:0]), .o_renq_ready(rd[3:2]), .o_rob_ready(rd[5:4]),
    .o_ldb_ready(rd[7:6]), .o_stb_ready(rd[9:8]));
  smt_share_l2_model smt_share_l2_model_i (.i_clk, .i_rst_n,
    .i_miss(i_fetch_miss), .o_return(i_l2_return));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  int c [10];
  logic [9:0] mr;
  logic [1:0] el, ef, er, ec;
  logic lf, lr, lc, ea;
  logic [15:0] ed;
  logic [1:0] eo;
  logic eh;
  logic [2:0] tw;
  logic [`DTB_ENTRIES-1:0] tva, tth, tgl;
  logic [`DTB_VPN_W-1:0] tv [`DTB_ENTRIES];
  logic [`DTB_PPN_W-1:0] ep, tp [`DTB_ENTRIES];
  logic [31:0] ip [2], rt [2];
  function automatic logic [1:0] arb(logic [1:0] r, logic l);
    if (r == 2'h3) return l ? 2'h1 : 2'h2;
    return r;
  endfunction : arb
  always @(posedge i_clk or negedge i_rst_n) begin
    int n;
    logic [31:0] nip;
    if (!i_rst_n) begin
      c = '{default: 0};
      {mr, ef, er, ec, ea, ed} = '0;
      {el, lf, lr, lc} = 5'h1F;
      {eo, eh, ep, tw, tva, tth, tgl} = '0;
      tv = '{default: '0};
      tp = '{default: '0};
      ip = '{default: '0};
      rt = '{default: '0};
    end else begin
      // lookup sees last cycle's mode and entries; a fill lands after it
      eo = i_order_viol & i_active;
      eh = 1'b0;
      ep = '0;
      for (int i = 0; i < `DTB_ENTRIES; i++)
        if (i_dtb_lookup && tva[i] && tv[i] == i_dtb_vpn &&
            (tth[i] == i_dtb_thread || (ea && tgl[i]))) begin
          eh = 1'b1;
          ep = tp[i];
        end
      if (i_dtb_fill) begin
        tva[tw] = 1'b1;
        tth[tw] = i_dtb_fill_thread;
        tgl[tw] = i_dtb_fill_global;
        tv[tw] = i_dtb_fill_vpn;
        tp[tw] = i_dtb_fill_ppn;
        tw++;
      end
      // pointer advances on the grant shown last cycle
      for (int t = 0; t < 2; t++) begin
        nip = i_ret[t] ? rt[t] : (i_branch[t] || i_call[t]) ? i_target
              : ef[t] ? ip[t] + 32'h10 : ip[t];
        if (i_call[t]) rt[t] = ip[t] + 32'h4;
        ip[t] = nip;
      end
      ef = arb(fq & el, lf);
      er = arb(i_retire_ready, lr);
      ec = arb(i_store_pending, lc);
      lf = (ef == 2'h0) ? lf : ef[1];
      lr = (er == 2'h0) ? lr : er[1];
      lc = (ec == 2'h0) ? lc : ec[1];
      // a miss beats a refill arriving on the same edge
      el = (el | i_l2_return) & ~i_fetch_miss;
      ea = i_ctx_bit;
      ed = '0;
      n = 0;
      for (int i = 0; i < 16; i++)
        if (i_sched_ready[i] && n < `DISPATCH_MAX) begin
          ed[i] = 1'b1;
          n++;
        end
      for (int k = 0; k < 10; k++) begin
        if (!i_active[k % 2]) c[k] = 0;
        else c[k] += (al[k] && mr[k]) - (fr[k] && c[k] > 0);
        mr[k] = i_active[k % 2] && c[k] < dp[k / 2] / 2;
      end
    end
  end
  // ----------------------------------------
  // checks and stimulus
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic compare();
    chk("fetch grant", o_fetch_grant, ef);
    chk("retire grant", o_retire_grant, er);
    chk("commit grant", o_commit_grant, ec);
    chk("dispatch", o_dispatch, ed);
    chk("cache mode", o_l1_adaptive, ea);
    chk("ready", rd, mr);
    chk("order flush", o_order_flush, eo);
    chk("dtb hit", o_dtb_hit, eh);
    chk("dtb ppn", o_dtb_ppn, ep);
    chk("thread 0 pointer", o_ip0, ip[0]);
    chk("thread 1 pointer", o_ip1, ip[1]);
    chk("thread 0 return top", o_ret_top0, rt[0]);
    chk("thread 1 return top", o_ret_top1, rt[1]);
  endtask : compare
  function automatic logic [1:0] rb();
    return ($urandom_range(3) == 0) ? 2'($urandom) : 2'h3;
  endfunction : rb
  task automatic zero();
    {i_active, freq, i_fetch_miss, i_retire_ready, i_store_pending} = '0;
    {al, fr, i_order_viol, i_branch, i_call, i_ret, i_sched_ready} = '0;
    {i_ctx_bit, i_dtb_lookup, i_dtb_thread, i_dtb_fill} = '0;
    {i_dtb_fill_thread, i_dtb_fill_global, i_dtb_vpn} = '0;
    {i_dtb_fill_vpn, i_dtb_fill_ppn, i_target} = '0;
  endtask : zero
  task automatic run(string nm, int n, int pa, int pf, bit ra);
    repeat (n) begin
      @(negedge i_clk);
      if (i_rst_n) compare();
      if (ra && $urandom_range(15) == 0) i_active = 2'($urandom);
      freq = rb() & i_active;
      i_retire_ready = rb() & i_active;
      i_store_pending = rb() & i_active;
      i_fetch_miss = ($urandom_range(15) == 0) ? 2'($urandom) : 2'h0;
      i_fetch_miss &= i_active;
      for (int k = 0; k < 10; k++) begin
        al[k] = $urandom_range(99) < pa;
        fr[k] = $urandom_range(99) < pf;
      end
      {i_order_viol, i_branch, i_call, i_ret, i_sched_ready, i_ctx_bit,
        i_dtb_lookup, i_dtb_thread, i_dtb_fill, i_dtb_fill_thread,
        i_dtb_fill_global} = 30'($urandom);
      // few page numbers so lookups really hit
      i_dtb_vpn = 20'($urandom_range(7));
      i_dtb_fill_vpn = 20'($urandom_range(7));
      i_dtb_fill_ppn = 20'($urandom);
      i_target = $urandom;
    end
    $display("test %s done, mismatches %0d", nm, error_cnt);
  endtask : run
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    zero();
    i_rst_n = 1'b0;
    void'($urandom(32'hF4AB));
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    i_active = 2'h3;
    run("mixed traffic", 2000, 50, 50, 1'b0);
    run("fill to cap", 200, 90, 0, 1'b0);
    run("drain", 200, 0, 90, 1'b0);
    run("thread toggle", 2000, 50, 40, 1'b1);
    @(negedge i_clk);
    zero();
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    i_active = 2'h3;
    run("after reset", 500, 60, 40, 1'b0);
    finish_test();
  end
  // run needs about 5000 cycles, so this only trips on a hang
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule : two_thread_pipeline_sharing_bench
bind two_thread_pipeline_sharing smt_share_properties smt_share_properties_i (.*);
